/* File: core/bpl_pkg.sv */
// constants, carriers and states shared by the boot packet loader
// Function
// - after reset run a short self-test, then drive attention low
// - attention stays low until the whole image arrives, then goes high
// - blank custom fuses: download only through the serial port as slave
// - programmed fuses choose start-up clocking and slave or master download
// - master mode fetches by itself; in slave mode the host paces packets
// - after a good download start executing without further command
// - a clock packet after fuse clocking replaces the fuse clock values
// - packet is command byte, three length bytes, four address bytes, payload
// - multi-byte fields travel least significant byte first
// - header packet: command 0x02, length 0x108, address is the start address
// - header payload: image length word, filler word, 256-byte signature
// - image data packets are expected only after a valid header
// - data packet: command 0x03, length is byte count, address is destination
// - image length reached: release attention and jump to the start address
// - clock packet: command 0x04, length 0x18, address zero
// - clock payload: three control words, lock word, baud bytes, pad, divider
// - a valid clock packet loads the clock, baud and divider registers at once
// - serial clock divider is loaded only in master boot, else discarded
// - loaded values are start-up values; software may rewrite them later
// - unsupported command codes are rejected with code 0x0FED0035
// - data before a valid header is rejected with code 0x0FED0036
// - slave mode shifts one 32-bit status code out during the next packet
package bpl_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned SELFTEST_NS = 1000;
    localparam int unsigned SELFTEST_CYC = (SELFTEST_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] TEST_LAST = 8'(SELFTEST_CYC - 1);
    localparam logic [7:0] CMD_HDR = 8'h02;
    localparam logic [7:0] CMD_DATA = 8'h03;
    localparam logic [7:0] CMD_PLL = 8'h04;
    localparam logic [23:0] HDR_LEN = 24'h000108;
    localparam logic [23:0] PLL_LEN = 24'h000018;
    localparam logic [23:0] MAX_LEN = 24'h001ff8;
    localparam logic [31:0] PLL_ADDR = 32'h00000000;
    localparam logic [23:0] LEN_LAST = 24'h000002;
    localparam logic [23:0] ADDR_LAST = 24'h000003;
    localparam logic [23:0] POS_IMG_LEN = 24'h000003;
    localparam logic [23:0] POS_CLK1 = 24'h000003;
    localparam logic [23:0] POS_CLK2 = 24'h000007;
    localparam logic [23:0] POS_CLK3 = 24'h00000b;
    localparam logic [23:0] POS_LOCK = 24'h00000f;
    localparam logic [23:0] POS_BAUD_LO = 24'h000010;
    localparam logic [23:0] POS_BAUD_HI = 24'h000011;
    localparam logic [23:0] POS_SCLK = 24'h000017;
    localparam logic [31:0] FLASH_READ = 32'h03000000;
    localparam logic [7:0] MIN_HALF = 8'h06;
    localparam logic ATTN_RST = 1'b1;
    localparam logic [31:0] ST_HDR_VALID = 32'h0fed0007;
    localparam logic [31:0] ST_PKT_VALID = 32'h0fed0008;
    localparam logic [31:0] ST_DL_DONE = 32'h0fed0009;
    localparam logic [31:0] ST_PLL_OK = 32'h0fed000e;
    localparam logic [31:0] ST_BAD_HDR = 32'h0fed0034;
    localparam logic [31:0] ST_BAD_TYPE = 32'h0fed0035;
    localparam logic [31:0] ST_NO_HDR = 32'h0fed0036;
    localparam logic [31:0] ST_BAD_PLL = 32'h0fed0039;
    localparam logic [31:0] ST_ALIGN = 32'h0fed003b;
    localparam logic [7:0] OFS_CLK1 = 8'h00;
    localparam logic [7:0] OFS_CLK2 = 8'h04;
    localparam logic [7:0] OFS_CLK3 = 8'h08;
    localparam logic [7:0] OFS_LOCK = 8'h0c;
    localparam logic [7:0] OFS_BAUD = 8'h10;
    localparam logic [7:0] OFS_SCLK = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [7:0] OFS_FLAGS = 8'h1c;
    localparam logic [7:0] OFS_EXEC = 8'h20;
    typedef struct packed {
        logic [31:0] clock_control_word1;
        logic [31:0] clock_control_word2;
        logic [31:0] clock_control_word3;
        logic [31:0] lock_control_word;
        logic [7:0] baud_divider_low;
        logic [7:0] baud_divider_high;
        logic [31:0] serial_clock_divider;
    } bpl_cfg_t;
    typedef struct packed {
        logic programmed;
        logic boot_master;
        bpl_cfg_t cfg;
    } bpl_fuse_t;
    typedef struct packed {
        logic we;
        logic [31:0] addr;
        logic [7:0] data;
    } bpl_mem_t;
    typedef enum logic [2:0] {
        ST_TEST = 3'h0,
        ST_CMD = 3'h1,
        ST_LEN = 3'h3,
        ST_ADDR = 3'h2,
        ST_DATA = 3'h6,
        ST_RUN = 3'h4
    } bpl_state_t;
endpackage

/* File: core/bpl_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module bpl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // asynchronous in, filtered out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } bpl_sync_t;
    bpl_sync_t r;
    bpl_sync_t n;

    // a bit changes only once stages two and three agree
    always_comb begin
        n.s1 = din;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.q = (r.s2 & ~(r.s2 ^ r.s3)) | (r.q & (r.s2 ^ r.s3));
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= {RST, RST, RST, RST};
        end else begin
            r <= n;
        end
    end

    assign dout = r.q;
endmodule
`default_nettype wire

/* File: core/bpl_spi_mst.sv */
// serial master that streams bytes from flash after a read opcode
`timescale 1ns/1ps
`default_nettype none
module bpl_spi_mst
    import bpl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control
    input wire logic en,
    input wire logic stop,
    input wire logic [7:0] half_div,
    // pins
    input wire logic miso,
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    // received bytes
    output logic byte_v,
    output logic [7:0] byte_d
);
    typedef struct packed {
        logic act;
        logic done;
        logic sclk;
        logic cs_n;
        logic [7:0] divc;
        logic [5:0] cmdc;
        logic [2:0] bitc;
        logic [31:0] tx;
        logic [7:0] rx;
        logic bv;
    } bpl_mst_t;
    bpl_mst_t r;
    bpl_mst_t n;
    logic [7:0] half;

    assign half = (half_div < MIN_HALF) ? MIN_HALF : half_div;

    // mode 0 clocking, sample late in the high half to cover input sync delay
    always_comb begin
        n = r;
        n.bv = 1'b0;
        if (!r.act) begin
            if (en && !r.done) begin
                n.act = 1'b1;
                n.cs_n = 1'b0;
                n.tx = FLASH_READ;
                n.divc = 8'h00;
            end
        end else if (stop) begin
            n.act = 1'b0;
            n.done = 1'b1;
            n.cs_n = 1'b1;
            n.sclk = 1'b0;
        end else if (r.divc == half) begin
            n.divc = 8'h00;
            n.sclk = ~r.sclk;
            if (r.sclk) begin
                n.rx = {r.rx[6:0], miso};
                n.tx = {r.tx[30:0], 1'b0};
                n.bitc = r.bitc + 3'h1;
                if (r.cmdc != 6'h20) begin
                    n.cmdc = r.cmdc + 6'h01;
                end else if (r.bitc == 3'h7) begin
                    n.bv = 1'b1;
                end
            end
        end else begin
            n.divc = r.divc + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '{cs_n: 1'b1, default: '0};
        end else begin
            r <= n;
        end
    end

    assign sclk = r.sclk;
    assign cs_n = r.cs_n;
    assign mosi = r.tx[31];
    assign byte_v = r.bv;
    assign byte_d = r.rx;
endmodule
`default_nettype wire

/* File: core/bpl_loader.sv */
// boot packet loader: fuse choice, packet parser, clock registers, wishbone slave
//
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module bpl_loader
    import bpl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // one-time fuses
    input wire bpl_fuse_t fuse,
    // serial slave pins
    input wire logic s_sclk,
    input wire logic s_cs_n,
    input wire logic s_mosi,
    output logic s_miso,
    output logic s_miso_oe,
    // serial master pins
    output logic m_sclk,
    output logic m_cs_n,
    output logic m_mosi,
    input wire logic m_miso,
    // memory write port
    output bpl_mem_t mem,
    // boot outputs
    output logic host_attn_n,
    output logic run,
    output logic [31:0] exec_addr,
    output bpl_cfg_t cfg,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    typedef struct packed {
        bpl_state_t st;
        logic [7:0] test_cnt;
        logic master;
        logic attn_n;
        logic run;
        logic hdr_ok;
        logic reject;
        logic [7:0] cmd;
        logic [23:0] len;
        logic [31:0] addr;
        logic [23:0] cnt;
        logic [31:0] sh;
        logic [31:0] img_len;
        logic [31:0] rx_total;
        logic [31:0] exec_addr;
        logic [31:0] code;
        bpl_cfg_t cfg;
        bpl_cfg_t stage;
        bpl_mem_t mem;
        logic [2:0] bitc;
        logic [7:0] rxb;
        logic bv;
        logic sclk_d;
        logic [31:0] tx;
        logic miso_oe;
        logic mst_go;
        logic ack;
        logic [31:0] rdat;
    } bpl_core_t;

    localparam bpl_core_t CORE_RST = '{st: ST_TEST, attn_n: ATTN_RST, default: '0};

    bpl_core_t r;
    bpl_core_t n;
    logic [2:0] s_pins;
    logic m_miso_s;
    logic m_bv;
    logic [7:0] m_byte;
    logic bv_in;
    logic [7:0] bd;
    logic [31:0] nsh;
    logic [32:0] chk;

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] bpl_merge(input logic [31:0] o, input logic [31:0] d,
                                              input logic [3:0] s);
        logic [31:0] v;
        v = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                v[8*i +: 8] = d[8*i +: 8];
            end
        end
        return v;
    endfunction

    // header check: reject flag over status code
    function automatic logic [32:0] bpl_check(input logic [7:0] c, input logic [23:0] l,
                                              input logic [31:0] a, input logic h);
        logic [32:0] v;
        v = {1'b1, ST_BAD_TYPE};
        unique case (c)
            CMD_HDR: begin
                v = (l == HDR_LEN) ? {1'b0, ST_HDR_VALID} : {1'b1, ST_BAD_HDR};
            end
            CMD_DATA: begin
                if (!h) begin
                    v = {1'b1, ST_NO_HDR};
                end else if ((l[2:0] != 3'h0) || (a[2:0] != 3'h0) || (l > MAX_LEN)) begin
                    v = {1'b1, ST_ALIGN};
                end else begin
                    v = {1'b0, ST_PKT_VALID};
                end
            end
            CMD_PLL: begin
                v = ((l == PLL_LEN) && (a == PLL_ADDR)) ? {1'b0, ST_PLL_OK} : {1'b1, ST_BAD_PLL};
            end
            default: begin
                v = {1'b1, ST_BAD_TYPE};
            end
        endcase
        return v;
    endfunction

    // slave pins pass the three-stage filter; cs idles high
    bpl_sync #(.W(3), .RST(3'h2)) u_sync_s (
        .clk(clk),
        .srst(srst),
        .din({s_sclk, s_cs_n, s_mosi}),
        .dout(s_pins)
    );

    bpl_sync #(.W(1), .RST(1'b0)) u_sync_m (
        .clk(clk),
        .srst(srst),
        .din(m_miso),
        .dout(m_miso_s)
    );

    // flash fetch engine, divider taken from the live register
    bpl_spi_mst u_mst (
        .clk(clk),
        .srst(srst),
        .en(r.mst_go),
        .stop(r.run),
        .half_div(r.cfg.serial_clock_divider[7:0]),
        .miso(m_miso_s),
        .sclk(m_sclk),
        .cs_n(m_cs_n),
        .mosi(m_mosi),
        .byte_v(m_bv),
        .byte_d(m_byte)
    );

    // byte source follows the chosen boot port
    assign bv_in = r.master ? m_bv : r.bv;
    assign bd = r.master ? m_byte : r.rxb;
    assign nsh = {bd, r.sh[31:8]};
    assign chk = bpl_check(r.cmd, r.len, nsh, r.hdr_ok);

    always_comb begin
        n = r;
        n.bv = 1'b0;
        n.ack = 1'b0;
        n.mem.we = 1'b0;
        n.mst_go = 1'b0;

        // slave deserialiser, msb first, status shifts out on the same edges
        n.sclk_d = s_pins[2];
        n.miso_oe = ~r.master & ~s_pins[1];
        if (s_pins[1]) begin
            n.bitc = 3'h0;
        end else if (s_pins[2] && !r.sclk_d && !r.master) begin
            n.rxb = {r.rxb[6:0], s_pins[0]};
            n.bitc = r.bitc + 3'h1;
            n.tx = {r.tx[30:0], 1'b0};
            n.bv = (r.bitc == 3'h7);
        end

        // wishbone classic slave, one wait state, unmapped reads zero
        if (wb_cyc_i && wb_stb_i && !r.ack) begin
            n.ack = 1'b1;
            unique case (wb_adr_i)
                OFS_CLK1: n.rdat = r.cfg.clock_control_word1;
                OFS_CLK2: n.rdat = r.cfg.clock_control_word2;
                OFS_CLK3: n.rdat = r.cfg.clock_control_word3;
                OFS_LOCK: n.rdat = r.cfg.lock_control_word;
                OFS_BAUD: n.rdat = {16'h0000, r.cfg.baud_divider_high, r.cfg.baud_divider_low};
                OFS_SCLK: n.rdat = r.cfg.serial_clock_divider;
                OFS_STAT: n.rdat = r.code;
                OFS_FLAGS: n.rdat = {28'h0000000, r.master, r.hdr_ok, r.run, r.attn_n};
                OFS_EXEC: n.rdat = r.exec_addr;
                default: n.rdat = 32'h00000000;
            endcase
            if (wb_we_i) begin
                n.rdat = 32'h00000000;
                unique case (wb_adr_i)
                    OFS_CLK1: n.cfg.clock_control_word1 = bpl_merge(r.cfg.clock_control_word1, wb_dat_i, wb_sel_i);
                    OFS_CLK2: n.cfg.clock_control_word2 = bpl_merge(r.cfg.clock_control_word2, wb_dat_i, wb_sel_i);
                    OFS_CLK3: n.cfg.clock_control_word3 = bpl_merge(r.cfg.clock_control_word3, wb_dat_i, wb_sel_i);
                    OFS_LOCK: n.cfg.lock_control_word = bpl_merge(r.cfg.lock_control_word, wb_dat_i, wb_sel_i);
                    OFS_BAUD: begin
                        if (wb_sel_i[0]) begin
                            n.cfg.baud_divider_low = wb_dat_i[7:0];
                        end
                        if (wb_sel_i[1]) begin
                            n.cfg.baud_divider_high = wb_dat_i[15:8];
                        end
                    end
                    OFS_SCLK: n.cfg.serial_clock_divider = bpl_merge(r.cfg.serial_clock_divider, wb_dat_i, wb_sel_i);
                    default: ;
                endcase
            end
        end

        // packet parser; placed last so its loads win over a same-cycle write
        unique case (r.st)
            ST_TEST: begin
                n.test_cnt = r.test_cnt + 8'h01;
                if (r.test_cnt == TEST_LAST) begin
                    n.st = ST_CMD;
                    n.attn_n = 1'b0;
                    n.master = fuse.programmed & fuse.boot_master;
                    n.mst_go = fuse.programmed & fuse.boot_master;
                    if (fuse.programmed) begin
                        n.cfg = fuse.cfg;
                    end
                end
            end
            ST_CMD: begin
                if (bv_in) begin
                    n.cmd = bd;
                    n.cnt = 24'h000000;
                    n.st = ST_LEN;
                end
            end
            ST_LEN: begin
                if (bv_in) begin
                    n.sh = nsh;
                    n.cnt = r.cnt + 24'h000001;
                    if (r.cnt == LEN_LAST) begin
                        n.len = nsh[31:8];
                        n.cnt = 24'h000000;
                        n.st = ST_ADDR;
                    end
                end
            end
            ST_ADDR: begin
                if (bv_in) begin
                    n.sh = nsh;
                    n.cnt = r.cnt + 24'h000001;
                    if (r.cnt == ADDR_LAST) begin
                        n.addr = nsh;
                        n.cnt = 24'h000000;
                        n.reject = chk[32];
                        n.code = chk[31:0];
                        if (r.len == 24'h000000) begin
                            n.st = ST_CMD;
                            n.tx = chk[31:0];
                        end else begin
                            n.st = ST_DATA;
                        end
                    end
                end
            end
            ST_DATA: begin
                if (bv_in) begin
                    n.sh = nsh;
                    n.cnt = r.cnt + 24'h000001;
                    if (!r.reject) begin
                        unique case (r.cmd)
                            CMD_HDR: begin
                                if (r.cnt == POS_IMG_LEN) begin
                                    n.img_len = nsh;
                                end
                            end
                            CMD_DATA: begin
                                n.mem.we = 1'b1;
                                n.mem.addr = r.addr + {8'h00, r.cnt};
                                n.mem.data = bd;
                                n.rx_total = r.rx_total + 32'h00000001;
                            end
                            CMD_PLL: begin
                                if (r.cnt == POS_CLK1) n.stage.clock_control_word1 = nsh;
                                if (r.cnt == POS_CLK2) n.stage.clock_control_word2 = nsh;
                                if (r.cnt == POS_CLK3) n.stage.clock_control_word3 = nsh;
                                if (r.cnt == POS_LOCK) n.stage.lock_control_word = nsh;
                                if (r.cnt == POS_BAUD_LO) n.stage.baud_divider_low = bd;
                                if (r.cnt == POS_BAUD_HI) n.stage.baud_divider_high = bd;
                                if (r.cnt == POS_SCLK) n.stage.serial_clock_divider = nsh;
                            end
                            default: ;
                        endcase
                    end
                    if (r.cnt == r.len - 24'h000001) begin
                        n.st = ST_CMD;
                        n.tx = r.code;
                        if (!r.reject && (r.cmd == CMD_HDR)) begin
                            n.hdr_ok = 1'b1;
                            n.exec_addr = r.addr;
                            n.rx_total = 32'h00000000;
                        end
                        if (!r.reject && (r.cmd == CMD_PLL)) begin
                            n.cfg = n.stage;
                            if (!r.master) begin
                                n.cfg.serial_clock_divider = r.cfg.serial_clock_divider;
                            end
                        end
                    end
                    if (!r.reject && (r.cmd == CMD_DATA) && (n.rx_total == r.img_len)) begin
                        n.st = ST_RUN;
                        n.attn_n = 1'b1;
                        n.run = 1'b1;
                        n.code = ST_DL_DONE;
                        n.tx = ST_DL_DONE;
                    end
                end
            end
            ST_RUN: ;
            default: n.st = ST_CMD;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= CORE_RST;
        end else begin
            r <= n;
        end
    end

    // every output but the master pins straight from the state register
    assign s_miso = r.tx[31];
    assign s_miso_oe = r.miso_oe;
    assign mem = r.mem;
    assign host_attn_n = r.attn_n;
    assign run = r.run;
    assign exec_addr = r.exec_addr;
    assign cfg = r.cfg;
    assign wb_dat_o = r.rdat;
    assign wb_ack_o = r.ack;
endmodule
`default_nettype wire

/* File: dv/bpl_loader_asserts.sv */
// concurrent checks on the boot packet loader ports
`timescale 1ns/1ps
`default_nettype none
module bpl_loader_asserts
    import bpl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // boot side
    input wire bpl_fuse_t fuse,
    input wire logic s_miso_oe,
    input wire logic m_cs_n,
    input wire bpl_mem_t mem,
    input wire logic host_attn_n,
    input wire logic run,
    input wire logic [31:0] exec_addr,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // boot progress
    self_test_a: assert property ($fell(srst) |-> host_attn_n [*8]) else $error("attention early");
    attn_done_a: assert property (run |-> host_attn_n) else $error("attention low while running");
    attn_hold_a: assert property (!host_attn_n && !run |=> !host_attn_n || run) else $error("attn rose");
    attn_rise_a: assert property ($rose(host_attn_n) |-> run) else $error("attention without run");
    run_hold_a: assert property (run |=> run && $stable(exec_addr)) else $error("run dropped");
    late_write_a: assert property (mem.we |-> !$past(run)) else $error("write after done");
    // port choice
    oe_slave_a: assert property (s_miso_oe |-> !(fuse.programmed && fuse.boot_master)) else $error("slave oe");
    mst_fetch_a: assert property (!m_cs_n |-> fuse.programmed && fuse.boot_master) else $error("master cs");
    // bus answer
    ack_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    run_c: cover property ($rose(run));
    write_c: cover property (mem.we);
    ready_c: cover property ($fell(host_attn_n));
endmodule
bind bpl_loader bpl_loader_asserts chk_u (.clk(clk), .srst(srst), .fuse(fuse), .s_miso_oe(s_miso_oe),
    .m_cs_n(m_cs_n), .mem(mem), .host_attn_n(host_attn_n), .run(run), .exec_addr(exec_addr),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

/* File: dv/bpl_host_model.sv */
// external serial master that paces packets into the loader
`timescale 1ns/1ps
`default_nettype none
module bpl_host_model (
    // clock
    input wire logic clk,
    // serial pins
    input wire logic miso,
    output logic sclk,
    output logic cs_n,
    output logic mosi
);
    logic [31:0] st;
    int nb;
    // idle link
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
        st = '0;
        nb = 0;
    end
    // one byte msb first, status taken before each rising edge
    task tx(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sclk <= 1'b0;
            mosi <= b[i];
            repeat (5) @(posedge clk);
            if (nb < 32) st = {st[30:0], miso};
            nb++;
            sclk <= 1'b1;
            repeat (5) @(posedge clk);
        end
    endtask
    // whole packet, header fields lsb first
    task pkt(input logic [7:0] c, input logic [23:0] l, input logic [31:0] a, input logic [31:0] w0,
        input logic [7:0] s);
        logic [63:0] h;
        h = {a, l, c};
        nb = 0;
        cs_n <= 1'b0;
        @(posedge clk);
        for (int k = 0; k < 8; k++) tx(h[8*k+:8]);
        for (int i = 0; i < int'(l); i++) tx(i < 4 ? w0[8*i+:8] : s + 8'(i));
        sclk <= 1'b0;
        mosi <= ~mosi;
        repeat (5) @(posedge clk);
        cs_n <= 1'b1;
        repeat (20) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: dv/bpl_loader_tb.sv */
// self-checking bench for the boot packet loader
`timescale 1ns/1ps
`default_nettype none
module bpl_loader_tb
    import bpl_pkg::*;
;
    logic clk, srst, wb_cyc, wb_stb, wb_we, sclk, cs_n, mosi, s_miso, host_attn_n, run, wb_ack_o, s_miso_oe;
    logic [7:0] wb_adr, exp_d;
    logic [31:0] wb_dat, q, exp_a, exec_addr, wb_dat_o;
    int errors, total_checks, nw;
    bpl_mem_t mem;
    bpl_cfg_t cfg;
    bpl_fuse_t fuse;
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    bpl_loader dut_u (.clk(clk), .srst(srst), .fuse(fuse), .s_sclk(sclk), .s_cs_n(cs_n), .s_mosi(mosi),
        .s_miso(s_miso), .s_miso_oe(s_miso_oe), .m_sclk(), .m_cs_n(), .m_mosi(), .m_miso(1'b0), .mem(mem),
        .host_attn_n(host_attn_n), .run(run), .exec_addr(exec_addr), .cfg(cfg), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    bpl_host_model host_u (.clk(clk), .miso(s_miso_oe ? s_miso : ~s_miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // classic single wishbone cycle
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask
    task conclude;
        if (errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // memory writes must ascend through the image
    always @(posedge clk) begin
        if (mem.we === 1'b1) begin
            chk(mem.addr, exp_a, "mem addr");
            chk(32'(mem.data), 32'(exp_d), "mem data");
            exp_a <= exp_a + 32'h1;
            exp_d <= exp_d + 8'h1;
            nw <= nw + 1;
        end
    end
    // watchdog
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        conclude();
    end
    initial begin
        {fuse, srst, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = {178'h0, 1'b1, 43'h0};
        {exp_a, exp_d, nw, errors, total_checks} = {32'h200, 8'h40, 96'h0};
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (100) @(posedge clk);
        chk(host_attn_n, 1'b1, "attn in self-test");
        wb(1'b1, OFS_CLK1, 32'h12345678);
        wb(1'b1, OFS_SCLK, 32'h55);
        wb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0, "unmapped read");
        wb(1'b0, OFS_CLK1, 32'h0);
        chk(q, 32'h12345678, "ctrl1 readback");
        repeat (110) @(posedge clk);
        chk(host_attn_n, 1'b0, "attn ready");
        host_u.pkt(8'h07, 24'h0, 32'h0, 32'h0, 8'h0);
        host_u.pkt(CMD_DATA, 24'h8, 32'h100, 32'h0, 8'h0);
        chk(host_u.st, ST_BAD_TYPE, "status bad type");
        chk(nw, 0, "writes before header");
        host_u.pkt(CMD_PLL, PLL_LEN, PLL_ADDR, 32'hcafe0001, 8'h10);
        chk(host_u.st, ST_NO_HDR, "status no header");
        chk(cfg.clock_control_word1, 32'hcafe0001, "ctrl1");
        chk(cfg.clock_control_word2, 32'h17161514, "ctrl2");
        chk(cfg.clock_control_word3, 32'h1b1a1918, "ctrl3");
        chk(cfg.lock_control_word, 32'h1f1e1d1c, "lock");
        chk({cfg.baud_divider_high, cfg.baud_divider_low}, 32'h2120, "baud");
        chk(cfg.serial_clock_divider, 32'h55, "divider kept");
        wb(1'b1, OFS_CLK2, 32'haa);
        wb(1'b0, OFS_CLK2, 32'h0);
        chk(q, 32'haa, "ctrl2 rewrite");
        host_u.pkt(CMD_HDR, HDR_LEN, 32'h8000, 32'h10, 8'h0);
        chk(host_u.st, ST_PLL_OK, "status clock");
        host_u.pkt(CMD_DATA, 24'h8, 32'h200, 32'h43424140, 8'h40);
        chk(host_u.st, ST_HDR_VALID, "status header");
        chk(host_attn_n, 1'b0, "attn mid image");
        host_u.pkt(CMD_DATA, 24'h8, 32'h208, 32'h4b4a4948, 8'h48);
        chk(host_u.st, ST_PKT_VALID, "status data");
        chk(nw, 16, "write count");
        chk(run, 1'b1, "run");
        chk(host_attn_n, 1'b1, "attn done");
        chk(exec_addr, 32'h8000, "start address");
        {fuse, srst} <= {2'b10, cfg, 1'b1};
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (210) @(posedge clk);
        chk(cfg.clock_control_word1, 32'hcafe0001, "fuse ctrl1");
        host_u.pkt(CMD_PLL, PLL_LEN, PLL_ADDR, 32'h0badf00d, 8'h10);
        chk(cfg.clock_control_word1, 32'h0badf00d, "fuse replaced");
        conclude();
    end
endmodule
`default_nettype wire
